// *** src/regport_pkg.sv ***
// Constants, types and carriers for the serial register port
package regport_pkg;
   // ************************************************************
   // Slave address and internal register map
   // ************************************************************
   localparam logic [6:0] BASE_ADDR = 7'h20;
   localparam int ADDR_STEP = 3;
   localparam logic [7:0] REG_CFG = 8'h00;
   localparam logic [7:0] REG_PIN_STATE = 8'h01;
   localparam logic [7:0] REG_PULLDOWN = 8'h02;
   localparam logic [7:0] REG_DAC_BASE = 8'h80;
   localparam logic [7:0] BLK_FIRST = 8'hF0;
   localparam logic [7:0] BLK_LAST = 8'hF5;
   localparam logic [7:0] BLK_DAC = 8'hF0;
   localparam int DAC_COUNT = 12;
   localparam int WORD_BYTES = 2;
   localparam logic [5:0] DAC_BLOCK_BYTES = 6'd24;
   localparam logic [5:0] BLOCK_MAX_BYTES = 6'd34;
   localparam logic [5:0] IDX_MAX = 6'h3F;
   localparam int CFG_TOUT_DIS = 0;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] PULLDOWN_RESET = 8'hFF;
   localparam logic [7:0] IDLE_READ = 8'hFF;
   localparam logic [15:0] DAC_RESET = 16'h0000;
   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_MHZ = 25;
   localparam int TOUT_US = 25000;
   localparam int TOUT_CYCLES_DEF = TOUT_US * CLK_MHZ;
   localparam int TOUT_W = 20;
   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_ACK = 3'b010,
      ST_RX = 3'b011,
      ST_TX = 3'b100,
      ST_MACK = 3'b101,
      ST_IGNORE = 3'b110
   } state_e;
   typedef logic [1:0] level_t;
   typedef logic [15:0] dac_word_t;
   typedef struct packed {
      logic scl;
      logic sda;
   } twire_s;
   typedef struct packed {
      logic out;
      logic oeN;
   } pin_out_s;
endpackage

// *** src/i2c_slave_register_port.sv ***
// Two-wire slave register port with GPIO and DAC data registers
// Behaviour
// - Pin state register mirrors GPIO pins continuously
// - Control bit one releases pin, zero pulls low
// - Slave only, never drives clock or START
// - Eight-bit units, address byte then data
// - Direction one reads, zero writes
// - One or two byte registers, blocks longer
// - Most significant byte and bit first
// - Receiver acknowledges every byte but the master's last read byte, low means ack
// - STOP ends transaction, interface goes idle
// - Repeated START acts exactly like START
// - Two three-level selects give nine addresses
// - Address is base plus three hi plus lo
// - Pointers F0 to F5 are block commands
// - First block streams twelve DAC words, 24 bytes
// - Truncated block writes keep only whole words
// - Long low clock or held data resets interface
// - Config bit disables the bus timeout
// - START anytime resets and expects address byte
// - DAC register drives output directly, no load
`timescale 1ns/1ps
module i2c_slave_register_port #(
   parameter int TOUT_CYCLES = regport_pkg::TOUT_CYCLES_DEF
) (
   input wire logic clk,
   input wire logic rst,
   input wire regport_pkg::twire_s busIn,
   output regport_pkg::pin_out_s sdaPin,
   input wire regport_pkg::level_t addrSelectLo,
   input wire regport_pkg::level_t addrSelectHi,
   input wire logic [7:0] gpioIn,
   output logic [7:0] gpioOut,
   output logic [7:0] gpioOeN,
   output regport_pkg::dac_word_t [regport_pkg::DAC_COUNT-1:0] dacData
);
   import regport_pkg::*;

   if (TOUT_CYCLES < 1 || TOUT_CYCLES >= 2 ** TOUT_W) begin : g_bad_tout
      $error("TOUT_CYCLES does not fit the timeout counter");
   end

   localparam logic [TOUT_W-1:0] TOUT_LIM = TOUT_W'(TOUT_CYCLES);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      twire_s s1;
      twire_s s2;
      twire_s prev;
      logic [7:0] gpio1;
      logic [7:0] pinState;
      level_t lo1;
      level_t lo2;
      level_t hi1;
      level_t hi2;
      state_e st;
      logic [3:0] bitCnt;
      logic [7:0] shift;
      logic rw;
      logic sdaLow;
      logic nack;
      logic ptrSet;
      logic [7:0] ptr;
      logic [5:0] idx;
      logic [7:0] hiByte;
      logic [7:0] cfg;
      logic [7:0] pdCtrl;
      logic [TOUT_W-1:0] toutCnt;
      dac_word_t [DAC_COUNT-1:0] dac;
   } state_s;

   state_s q;
   state_s next_q;

   function automatic logic isDac(input logic [7:0] p);
      isDac = (p >= REG_DAC_BASE) && (p < REG_DAC_BASE + 8'(DAC_COUNT));
   endfunction

   // Read data for the current pointer and byte index
   function automatic logic [7:0] readByte(input state_s s);
      logic [3:0] di;
      dac_word_t w;
      di = 4'(s.ptr - REG_DAC_BASE);
      readByte = IDLE_READ;
      if (s.ptr == REG_CFG && s.idx == 6'd0) begin
         readByte = s.cfg;
      end else if (s.ptr == REG_PIN_STATE && s.idx == 6'd0) begin
         readByte = s.pinState;
      end else if (s.ptr == REG_PULLDOWN && s.idx == 6'd0) begin
         readByte = s.pdCtrl;
      end else if (isDac(s.ptr) && s.idx < 6'(WORD_BYTES)) begin
         w = s.dac[di];
         readByte = s.idx[0] ? w[7:0] : w[15:8];
      end else if (s.ptr == BLK_DAC && s.idx < DAC_BLOCK_BYTES) begin
         w = s.dac[s.idx[5:1]];
         readByte = s.idx[0] ? w[7:0] : w[15:8];
      end
   endfunction

   // ************************************************************
   // Next state
   // ************************************************************
   logic rise;
   logic fall;
   logic startDet;
   logic stopDet;
   logic byteEnd;
   logic match;
   logic [6:0] myAddr;
   logic [7:0] rb;

   always_comb begin
      next_q = q;
      rb = readByte(q);
      next_q.s1 = busIn;
      next_q.s2 = q.s1;
      next_q.prev = q.s2;
      next_q.gpio1 = gpioIn;
      next_q.pinState = q.gpio1;
      next_q.lo1 = addrSelectLo;
      next_q.lo2 = q.lo1;
      next_q.hi1 = addrSelectHi;
      next_q.hi2 = q.hi1;
      rise = q.s2.scl && !q.prev.scl;
      fall = !q.s2.scl && q.prev.scl;
      startDet = q.s2.scl && q.prev.scl && q.prev.sda && !q.s2.sda;
      stopDet = q.s2.scl && q.prev.scl && !q.prev.sda && q.s2.sda;
      byteEnd = fall && q.bitCnt == 4'd8;
      myAddr = BASE_ADDR + 7'(ADDR_STEP) * 7'(q.hi2) + 7'(q.lo2);
      match = q.shift[7:1] == myAddr;
      case (q.st)
         ST_ADDR, ST_RX: begin
            if (rise && q.bitCnt < 4'd8) begin
               next_q.shift = {q.shift[6:0], q.s2.sda};
               next_q.bitCnt = q.bitCnt + 4'd1;
            end
            if (byteEnd && q.st == ST_ADDR) begin
               if (match) begin
                  next_q.st = ST_ACK;
                  next_q.sdaLow = 1'b1;
                  next_q.rw = q.shift[0];
                  next_q.idx = 6'd0;
                  next_q.ptrSet = 1'b0;
               end else begin
                  next_q.st = ST_IGNORE;
               end
            end else if (byteEnd) begin
               next_q.st = ST_ACK;
               next_q.sdaLow = 1'b1;
               if (!q.ptrSet) begin
                  next_q.ptr = q.shift;
                  next_q.ptrSet = 1'b1;
               end else begin
                  if (q.ptr == REG_CFG && q.idx == 6'd0) begin
                     next_q.cfg = q.shift;
                  end else if (q.ptr == REG_PULLDOWN && q.idx == 6'd0) begin
                     next_q.pdCtrl = q.shift;
                  end else if (isDac(q.ptr) && q.idx < 6'(WORD_BYTES)) begin
                     if (!q.idx[0]) begin
                        next_q.hiByte = q.shift;
                     end else begin
                        next_q.dac[4'(q.ptr - REG_DAC_BASE)] = {q.hiByte, q.shift};
                     end
                  end else if (q.ptr == BLK_DAC && q.idx < DAC_BLOCK_BYTES) begin
                     // A word lands only when its low byte arrives
                     if (!q.idx[0]) begin
                        next_q.hiByte = q.shift;
                     end else begin
                        next_q.dac[q.idx[5:1]] = {q.hiByte, q.shift};
                     end
                  end
                  if (q.idx != IDX_MAX) begin
                     next_q.idx = q.idx + 6'd1;
                  end
               end
            end
         end
         ST_ACK: begin
            if (fall) begin
               next_q.bitCnt = 4'd0;
               next_q.sdaLow = 1'b0;
               if (q.rw) begin
                  next_q.st = ST_TX;
                  next_q.shift = rb;
                  next_q.sdaLow = !rb[7];
                  next_q.idx = q.idx + 6'd1;
               end else begin
                  next_q.st = ST_RX;
               end
            end
         end
         ST_TX: begin
            if (fall && q.bitCnt == 4'd7) begin
               next_q.st = ST_MACK;
               next_q.sdaLow = 1'b0;
            end else if (fall) begin
               next_q.shift = {q.shift[6:0], 1'b0};
               next_q.sdaLow = !q.shift[6];
               next_q.bitCnt = q.bitCnt + 4'd1;
            end
         end
         ST_MACK: begin
            if (rise) begin
               next_q.nack = q.s2.sda;
            end
            if (fall && q.nack) begin
               next_q.st = ST_IGNORE;
            end else if (fall) begin
               next_q.st = ST_TX;
               next_q.bitCnt = 4'd0;
               next_q.shift = rb;
               next_q.sdaLow = !rb[7];
               if (q.idx != IDX_MAX) begin
                  next_q.idx = q.idx + 6'd1;
               end
            end
         end
         default: begin
            next_q.sdaLow = 1'b0;
         end
      endcase
      if (stopDet) begin
         next_q.st = ST_IDLE;
         next_q.sdaLow = 1'b0;
      end
      if (startDet) begin
         next_q.st = ST_ADDR;
         next_q.bitCnt = 4'd0;
         next_q.sdaLow = 1'b0;
         next_q.nack = 1'b0;
      end
      // Saturating count of low clock or of our own held data line
      if (q.s2.scl && !q.sdaLow) begin
         next_q.toutCnt = '0;
      end else if (q.toutCnt != TOUT_LIM) begin
         next_q.toutCnt = q.toutCnt + TOUT_W'(1);
      end
      if (q.toutCnt == TOUT_LIM && !q.cfg[CFG_TOUT_DIS]) begin
         next_q.st = ST_IDLE;
         next_q.sdaLow = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= '0;
         q.s1 <= '{scl: 1'b1, sda: 1'b1};
         q.s2 <= '{scl: 1'b1, sda: 1'b1};
         q.prev <= '{scl: 1'b1, sda: 1'b1};
         q.st <= ST_IDLE;
         q.cfg <= CFG_RESET;
         q.pdCtrl <= PULLDOWN_RESET;
         q.dac <= {DAC_COUNT{DAC_RESET}};
      end else begin
         q <= next_q;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   // Open drain only: the pins are pulled low or left to the pull-up
   assign sdaPin.out = 1'b0;
   assign sdaPin.oeN = !q.sdaLow;
   assign gpioOut = 8'h00;
   assign gpioOeN = q.pdCtrl;
   assign dacData = q.dac;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_addrEnd;
      q.st == ST_ADDR && byteEnd;
   endsequence
   sequence s_rxEnd;
      q.st == ST_RX && byteEnd;
   endsequence

   property p_match;
      s_addrEnd ##0 match && !startDet && !stopDet |=> q.st == ST_ACK && !sdaPin.oeN;
   endproperty
   a_match: assert property (p_match) else $error("own address not acknowledged");
   property p_foreign;
      s_addrEnd ##0 !match && !startDet |=> q.st == ST_IGNORE ##1 sdaPin.oeN;
   endproperty
   a_foreign: assert property (p_foreign) else $error("foreign address acknowledged");
   property p_start;
      startDet && q.toutCnt != TOUT_LIM |=> q.st == ST_ADDR && q.bitCnt == 4'd0 && sdaPin.oeN;
   endproperty
   a_start: assert property (p_start) else $error("start did not reset interface");
   property p_stop;
      stopDet && !startDet |=> q.st == ST_IDLE && sdaPin.oeN;
   endproperty
   a_stop: assert property (p_stop) else $error("stop did not idle interface");
   property p_tout;
      q.toutCnt == TOUT_LIM && !q.cfg[CFG_TOUT_DIS] |=> q.st == ST_IDLE && sdaPin.oeN;
   endproperty
   a_tout: assert property (p_tout) else $error("timeout did not reset");
   property p_drive;
      !sdaPin.oeN |-> q.st == ST_ACK || q.st == ST_TX;
   endproperty
   a_drive: assert property (p_drive) else $error("data driven outside ack or send");
   property p_msb;
      q.st == ST_TX |-> sdaPin.oeN == q.shift[7];
   endproperty
   a_msb: assert property (p_msb) else $error("sent bit is not shift msb");
   property p_word;
      !(q.st == ST_RX && byteEnd && q.ptrSet && q.idx[0]) |=> $stable(dacData);
   endproperty
   a_word: assert property (p_word) else $error("dac changed without a whole word");
   property p_ptr;
      s_rxEnd ##0 !q.ptrSet |=> q.ptrSet && $stable(dacData) && q.ptr == $past(q.shift);
   endproperty
   a_ptr: assert property (p_ptr) else $error("first write byte not taken as pointer");
   property p_pins;
      ##2 1'b1 |-> q.pinState == $past(gpioIn, 2);
   endproperty
   a_pins: assert property (p_pins) else $error("pin state does not follow pins");
endmodule

// *** sim/twire_master.sv ***
// Bus master model that clocks and frames the register port
`timescale 1ns/1ps
module twire_master (
   input wire logic clk,
   input wire regport_pkg::pin_out_s sdaPin,
   output regport_pkg::twire_s busIn
);
   import regport_pkg::*;
   // ****************************************
   // Wire levels and bit timing
   // ****************************************
   logic scl = 1'b1;
   logic sdaDrv = 1'b1;
   // Pull-up: the line is low if either party pulls it
   assign busIn.scl = scl;
   assign busIn.sda = sdaDrv & sdaPin.oeN;
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Clock stands high outside frames; data moves only while it is low, except at START and STOP
   task automatic begin_frame();
      if (!scl) begin
         sdaDrv = 1'b1;
         tick(4);
         scl = 1'b1;
         tick(4);
      end
      sdaDrv = 1'b0;
      tick(4);
      scl = 1'b0;
      tick(1);
   endtask
   task automatic end_frame();
      sdaDrv = 1'b0;
      tick(3);
      scl = 1'b1;
      tick(4);
      sdaDrv = 1'b1;
      tick(8);
   endtask
   task automatic bit_io(input logic b, output logic s);
      sdaDrv = b;
      tick(3);
      scl = 1'b1;
      tick(4);
      s = busIn.sda;
      scl = 1'b0;
      tick(1);
   endtask
   task automatic send(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(b[i], s);
      bit_io(1'b1, s);
      ack = !s;
   endtask
   // Master acknowledges every read byte but the last
   task automatic recv(output logic [7:0] d, input logic last);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(last, s);
   endtask
endmodule

// *** sim/i2c_slave_register_port_tb.sv ***
// Self-checking bench for the serial register port
`timescale 1ns/1ps
module i2c_slave_register_port_tb;
   import regport_pkg::*;
   logic clk;
   logic rst = 1'b1;
   twire_s busIn;
   pin_out_s sdaPin;
   level_t lo = 2'd0;
   level_t hi = 2'd0;
   logic [7:0] gpioIn = 8'h00;
   logic [7:0] gpioOut;
   logic [7:0] gpioOeN;
   dac_word_t [DAC_COUNT-1:0] dacData;
   logic [6:0] me;
   logic [15:0] v;
   logic k;
   logic [7:0] q[$];
   int errors = 0;
   int totalChecks = 0;
   int cycles = 0;
   i2c_slave_register_port #(.TOUT_CYCLES(200)) dut (
      .clk(clk),
      .rst(rst),
      .busIn(busIn),
      .sdaPin(sdaPin),
      .addrSelectLo(lo),
      .addrSelectHi(hi),
      .gpioIn(gpioIn),
      .gpioOut(gpioOut),
      .gpioOeN(gpioOeN),
      .dacData(dacData)
   );
   twire_master bm (.clk(clk), .sdaPin(sdaPin), .busIn(busIn));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // ****************************************
   // Compare and access tasks
   // ****************************************
   task automatic chkWord(input logic [15:0] got, input logic [15:0] exp);
      totalChecks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chkBit(input logic got, input logic exp);
      chkWord({15'h0000, got}, {15'h0000, exp});
   endtask
   task automatic xfer(input logic [6:0] a, input logic [7:0] d[$], input logic ok);
      logic ack;
      bm.begin_frame();
      bm.send({a, 1'b0}, ack);
      chkBit(ack, ok);
      foreach (d[i]) begin
         if (ok) begin
            bm.send(d[i], ack);
            chkBit(ack, 1'b1);
         end
      end
      bm.end_frame();
   endtask
   task automatic rd(input logic [7:0] ptr, input int n, output logic [15:0] r);
      logic ack;
      logic [7:0] b;
      r = 16'h0000;
      bm.begin_frame();
      bm.send({me, 1'b0}, ack);
      bm.send(ptr, ack);
      bm.begin_frame();
      bm.send({me, 1'b1}, ack);
      chkBit(ack, 1'b1);
      for (int i = 0; i < n; i++) begin
         bm.recv(b, i == n - 1);
         r = {r[7:0], b};
      end
      bm.end_frame();
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", totalChecks, errors);
      if (errors == 0 && totalChecks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Hang guard, well above the roughly 10k cycles the tests need
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         errors++;
         summarize();
      end
   end
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      repeat (8) @(negedge clk);
      rst = 1'b0;
      bm.tick(4);
      chkWord({8'h00, gpioOeN}, {8'h00, PULLDOWN_RESET});
      chkWord({8'h00, gpioOut}, 16'h0000);
      chkWord(dacData[0], DAC_RESET);
      for (int h = 0; h < 3; h++) begin
         for (int l = 0; l < 3; l++) begin
            hi = 2'(h);
            lo = 2'(l);
            bm.tick(6);
            me = 7'(BASE_ADDR + ADDR_STEP * h + l);
            xfer(me ^ 7'h10, '{8'h80}, 1'b0);
            xfer(me, '{8'h80 + 8'(3 * h + l), 8'(3 * h + l), 8'hA0 + 8'(3 * h + l)}, 1'b1);
            chkWord(dacData[3 * h + l], {8'(3 * h + l), 8'hA0 + 8'(3 * h + l)});
         end
      end
      rd(8'h85, 2, v);
      chkWord(v, 16'h05A5);
      xfer(me, '{REG_PULLDOWN, 8'h5A}, 1'b1);
      chkWord({8'h00, gpioOeN}, 16'h005A);
      gpioIn = 8'hC3;
      rd(REG_PIN_STATE, 1, v);
      chkWord(v, 16'h00C3);
      xfer(me, '{BLK_DAC, 8'h11, 8'h22, 8'h33}, 1'b1);
      chkWord(dacData[0], 16'h1122);
      chkWord(dacData[1], 16'h01A1);
      q = '{BLK_DAC};
      for (int i = 0; i < 24; i++) q.push_back(8'hC0 + 8'(i));
      xfer(me, q, 1'b1);
      for (int i = 0; i < DAC_COUNT; i++) chkWord(dacData[i], {8'hC0 + 8'(2 * i), 8'hC1 + 8'(2 * i)});
      // START in mid-word: the half word is lost, the address byte comes next
      bm.begin_frame();
      bm.send({me, 1'b0}, k);
      bm.send(8'h80, k);
      bm.send(8'h77, k);
      bm.begin_frame();
      bm.send({me, 1'b0}, k);
      chkBit(k, 1'b1);
      bm.send(8'h82, k);
      bm.send(8'h12, k);
      bm.send(8'h34, k);
      bm.end_frame();
      chkWord(dacData[0], 16'hC0C1);
      chkWord(dacData[2], 16'h1234);
      // A long low clock drops the transfer; with the timeout off it survives
      for (int dis = 0; dis < 2; dis++) begin
         bm.begin_frame();
         bm.send({me, 1'b0}, k);
         bm.tick(300);
         bm.send(8'h83, k);
         chkBit(k, 1'(dis));
         bm.send(8'h56, k);
         bm.send(8'h78, k);
         bm.end_frame();
         chkWord(dacData[3], dis ? 16'h5678 : 16'hC6C7);
         xfer(me, '{REG_CFG, 8'h01}, 1'b1);
      end
      rd(REG_CFG, 1, v);
      chkWord(v, 16'h0001);
      rd(BLK_DAC, 2, v);
      chkWord(v, 16'hC0C1);
      chkBit(sdaPin.out, 1'b0);
      summarize();
   end
endmodule
